// ===== ssp_params.svh
// offsets, field positions, reset values and timing counts of the serial port
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// device register byte addresses
`define SSP_DATA_OFS   8'h80
`define SSP_ADDR_OFS   8'h84
`define SSP_CTRL_OFS   8'h88
`define SSP_ISTAT_OFS  8'h8C
`define SSP_IMASK_OFS  8'h90
`define SSP_STAT_OFS   8'h94
// controller register byte addresses
`define MST_CMD_OFS    8'h00
`define MST_STAT_OFS   8'h04
// control register fields
`define CTRL_EN_BIT    0
`define CTRL_CKP_BIT   1
`define CTRL_TEN_BIT   2
// status register fields
`define ST_SMP_BIT     7
`define ST_CKE_BIT     6
// interrupt status and mask fields
`define IRQ_EV_BIT     0
`define IRQ_OV_BIT     1
`define IRQ_STOP_BIT   2
// reset values
`define SSP_ADDR_RST   8'h00
`define SSP_CTRL_RST   3'h0
`define SSP_IRQ_RST    3'h0
// controller command codes
`define MST_CMD_START  2'h0
`define MST_CMD_STOP   2'h1
`define MST_CMD_WRITE  2'h2
`define MST_CMD_READ   2'h3
// timing: standard rate and half bit time in pclk cycles
`define SSP_STD_KBPS   100
`define SSP_CLK_MHZ    100
`define SSP_HALF_BIT_NS (1000000 / (2 * `SSP_STD_KBPS))
`define SSP_HALF_BIT_CYC ((`SSP_HALF_BIT_NS * `SSP_CLK_MHZ + 999) / 1000)
`endif

// ===== ssp_pkg.sv
// types shared by both ends of the serial link
package ssp_pkg;
	typedef logic [7:0]  addr_t;
	typedef logic [31:0] word_t;
	typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_HOLD, D_TXWAIT, D_TX, D_ACKIN} dev_state_t;
	typedef enum logic {M_IDLE, M_RUN} mst_state_t;
	typedef struct packed {
		dev_state_t  st;
		dev_state_t  ret;
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic [7:0]  sr;
		logic [3:0]  cnt;
		logic [1:0]  aphase;
		logic        scl_low;
		logic        sda_low;
		logic [7:0]  data;
		logic [7:0]  addr;
		logic        en;
		logic        clock_release_bit;
		logic        ten;
		logic        sample_phase_select;
		logic        cke;
		logic        bf;
		logic        ua;
		logic        da;
		logic        stop;
		logic        start;
		logic        rw;
		logic        prior;
		logic        ackin;
		logic [2:0]  ist;
		logic [2:0]  imask;
		logic [31:0] rdata;
		logic        err;
	} dev_regs_t;
	typedef struct packed {
		mst_state_t  st;
		logic [1:0]  cmd;
		logic [2:0]  sub;
		logic [3:0]  bitn;
		logic [15:0] tmr;
		logic [8:0]  tx;
		logic [8:0]  rx;
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic        scl_low;
		logic        sda_low;
		logic [31:0] rdata;
		logic        err;
	} mst_regs_t;
endpackage : ssp_pkg

// ===== i2c_link_if.sv
// two-wire link between the controller end and the device end
`timescale 1ns/1ns
interface i2c_link_if;
	logic dev_scl_o;
	logic dev_scl_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic mst_scl_o;
	logic mst_scl_oe_n;
	logic mst_sda_o;
	logic mst_sda_oe_n;
	wire  scl;
	wire  sda;
	// wired-and with pull-up: a released line reads high
	assign scl = (dev_scl_oe_n | dev_scl_o) & (mst_scl_oe_n | mst_scl_o);
	assign sda = (dev_sda_oe_n | dev_sda_o) & (mst_sda_oe_n | mst_sda_o);
	modport device (input scl, input sda,
		output dev_scl_o, output dev_scl_oe_n, output dev_sda_o, output dev_sda_oe_n);
	modport master (input scl, input sda,
		output mst_scl_o, output mst_scl_oe_n, output mst_sda_o, output mst_sda_oe_n);
endinterface : i2c_link_if

// ===== sync_serial_port_i2c_slave.sv
// device end: two-wire slave with buffer, address match and status registers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "ssp_params.svh"
module sync_serial_port_i2c_slave (
	input  wire logic          pclk,     // system clock
	input  wire logic          presetn,  // async reset, active low
	input  wire logic          ce,       // clock enable, freezes state when low
	input  wire logic          psel,     // apb select
	input  wire logic          penable,  // apb access phase
	input  wire logic          pwrite,   // apb direction
	input  wire ssp_pkg::addr_t paddr,   // apb byte address
	input  wire ssp_pkg::word_t pwdata,  // apb write data
	output ssp_pkg::word_t     prdata,   // apb read data
	output logic               pready,   // apb ready
	output logic               pslverr,  // apb error on unmapped address
	output logic               irq,      // level interrupt
	i2c_link_if.device         link      // two-wire pins
);
	import ssp_pkg::*;

	dev_regs_t r_q;
	dev_regs_t r_d;
	logic      scl_rise;
	logic      scl_fall;
	logic      bus_start;
	logic      bus_stop;
	logic      ovf;
	logic      hit7;
	logic      hit_lo;
	logic      acc;
	logic      wr;

	// edges are taken only from the second and third sync stages
	assign scl_rise  = r_q.scl_s[1] & ~r_q.scl_s[2];
	assign scl_fall  = ~r_q.scl_s[1] & r_q.scl_s[2];
	assign bus_start = r_q.scl_s[1] & r_q.scl_s[2] & ~r_q.sda_s[1] & r_q.sda_s[2];
	assign bus_stop  = r_q.scl_s[1] & r_q.scl_s[2] & r_q.sda_s[1] & ~r_q.sda_s[2];
	assign ovf       = r_q.bf | r_q.ist[`IRQ_OV_BIT];
	// address zero is the general call and never matches
	assign hit7      = (r_q.sr[7:1] == r_q.addr[7:1]) & (r_q.sr[7:1] != 7'h00);
	assign hit_lo    = r_q.sr == r_q.addr;
	assign acc       = psel & penable;
	assign wr        = acc & pwrite;

	// bus answers in the first access cycle
	assign pready  = acc;
	assign prdata  = r_q.rdata;
	assign pslverr = acc & r_q.err;
	assign irq     = |(r_q.ist & r_q.imask);

	// pins only ever pull low
	assign link.dev_scl_o    = 1'b0;
	assign link.dev_sda_o    = 1'b0;
	assign link.dev_scl_oe_n = ~r_q.scl_low;
	assign link.dev_sda_oe_n = ~r_q.sda_low;

	// next state of the whole port
	always_comb begin
		r_d = r_q;
		// three-stage synchronisers for fast and standard rates
		r_d.scl_s = {r_q.scl_s[1:0], link.scl};
		r_d.sda_s = {r_q.sda_s[1:0], link.sda};
		// read data captured in the setup cycle
		if (psel && !penable) begin
			r_d.err   = 1'b0;
			r_d.rdata = 32'h0000_0000;
			unique case (paddr)
				`SSP_DATA_OFS:  r_d.rdata[7:0] = r_q.data;
				`SSP_ADDR_OFS:  r_d.rdata[7:0] = r_q.addr;
				`SSP_CTRL_OFS:  r_d.rdata[2:0] = {r_q.ten, r_q.clock_release_bit, r_q.en};
				`SSP_ISTAT_OFS: r_d.rdata[2:0] = r_q.ist;
				`SSP_IMASK_OFS: r_d.rdata[2:0] = r_q.imask;
				`SSP_STAT_OFS:  r_d.rdata[7:0] = {r_q.sample_phase_select, r_q.cke, r_q.da, r_q.stop,
					r_q.start, r_q.rw, r_q.ua, r_q.bf};
				default:        r_d.err = 1'b1;
			endcase
		end
		// register writes and read side effects
		if (wr) begin
			unique case (paddr)
				`SSP_DATA_OFS: begin
					r_d.data = pwdata[7:0];
					r_d.bf   = 1'b1;
				end
				`SSP_ADDR_OFS: begin
					r_d.addr = pwdata[7:0];
					r_d.ua   = 1'b0;
				end
				`SSP_CTRL_OFS: begin
					r_d.en  = pwdata[`CTRL_EN_BIT];
					r_d.clock_release_bit = pwdata[`CTRL_CKP_BIT];
					r_d.ten = pwdata[`CTRL_TEN_BIT];
				end
				`SSP_STAT_OFS: begin
					r_d.sample_phase_select = pwdata[`ST_SMP_BIT];
					r_d.cke = pwdata[`ST_CKE_BIT];
				end
				`SSP_ISTAT_OFS: r_d.ist = r_q.ist & ~pwdata[2:0];
				`SSP_IMASK_OFS: r_d.imask = pwdata[2:0];
				default: ;
			endcase
		end
		if (acc && !pwrite && paddr == `SSP_DATA_OFS) begin
			r_d.bf = 1'b0;
		end
		// protocol engine; hardware sets come after clears so they win
		if (!r_q.en) begin
			r_d.st      = D_IDLE;
			r_d.scl_low = 1'b0;
			r_d.sda_low = 1'b0;
			r_d.start   = 1'b0;
			r_d.stop    = 1'b0;
		end else if (bus_start) begin
			r_d.st      = D_RX;
			r_d.cnt     = 4'h0;
			r_d.aphase  = 2'h1;
			r_d.scl_low = 1'b0;
			r_d.sda_low = 1'b0;
			r_d.start   = 1'b1;
			r_d.stop    = 1'b0;
		end else if (bus_stop) begin
			r_d.st                = D_IDLE;
			r_d.scl_low           = 1'b0;
			r_d.sda_low           = 1'b0;
			r_d.start             = 1'b0;
			r_d.stop              = 1'b1;
			r_d.rw                = 1'b0;
			r_d.prior             = 1'b0;
			r_d.ist[`IRQ_STOP_BIT] = 1'b1;
		end else begin
			unique case (r_q.st)
				D_IDLE: ;
				// shift eight bits in on rising edges
				D_RX: begin
					if (scl_rise) begin
						r_d.sr  = {r_q.sr[6:0], r_q.sda_s[1]};
						r_d.cnt = r_q.cnt + 4'h1;
					end else if (scl_fall && r_q.cnt == 4'h8) begin
						r_d.cnt = 4'h0;
						r_d.st  = D_IDLE;
						r_d.ret = D_IDLE;
						if (r_q.aphase == 2'h1 && hit7 && r_q.sr[0]) begin
							// read request: ten-bit needs a prior full match
							if (!r_q.ten || r_q.prior) begin
								r_d.rw      = 1'b1;
								r_d.st      = D_ACK;
								r_d.sda_low = 1'b1;
								r_d.ret     = D_TXWAIT;
								r_d.clock_release_bit     = 1'b0;
								r_d.da      = 1'b0;
							end
						end else if (r_q.aphase == 2'h0 || (r_q.aphase == 2'h1 && hit7) ||
							(r_q.aphase == 2'h2 && hit_lo)) begin
							r_d.st = D_ACK;
							if (ovf) begin
								r_d.ist[`IRQ_OV_BIT] = 1'b1;
								r_d.ret = (r_q.aphase == 2'h0) ? D_RX : D_IDLE;
							end else begin
								r_d.data    = r_q.sr;
								r_d.bf      = 1'b1;
								r_d.sda_low = 1'b1;
								r_d.da      = (r_q.aphase == 2'h0);
								r_d.ret     = D_RX;
								if (r_q.aphase == 2'h1) begin
									r_d.rw     = 1'b0;
									r_d.aphase = 2'h0;
									if (r_q.ten) begin
										r_d.ua     = 1'b1;
										r_d.prior  = 1'b0;
										r_d.aphase = 2'h2;
										r_d.ret    = D_HOLD;
									end
								end else if (r_q.aphase == 2'h2) begin
									r_d.ua     = 1'b1;
									r_d.prior  = 1'b1;
									r_d.aphase = 2'h0;
									r_d.ret    = D_HOLD;
								end
							end
						end
					end
				end
				// ninth clock: release data, raise interrupt, maybe stretch
				D_ACK: begin
					if (scl_fall) begin
						r_d.sda_low           = 1'b0;
						r_d.ist[`IRQ_EV_BIT]  = 1'b1;
						r_d.st                = r_q.ret;
						r_d.scl_low           = (r_q.ret == D_HOLD || r_q.ret == D_TXWAIT);
					end
				end
				// hold the clock low until software reloads the address
				D_HOLD: begin
					if (!r_q.ua) begin
						r_d.scl_low = 1'b0;
						r_d.st      = D_RX;
					end
				end
				// hold the clock while buffer empty and release clear
				D_TXWAIT: begin
					if (r_q.bf || r_q.clock_release_bit) begin
						r_d.sr      = r_q.data;
						r_d.bf      = 1'b0;
						r_d.clock_release_bit     = 1'b1;
						r_d.cnt     = 4'h0;
						r_d.sda_low = ~r_q.data[7];
						r_d.st      = D_TX;
					end
				end
				// first bit is set up while the clock is still held low
				D_TX: begin
					if (r_q.scl_low) begin
						r_d.scl_low = 1'b0;
					end else if (scl_fall) begin
						if (r_q.cnt == 4'h7) begin
							r_d.sda_low = 1'b0;
							r_d.st      = D_ACKIN;
						end else begin
							r_d.sda_low = ~r_q.sr[6];
							r_d.sr      = {r_q.sr[6:0], 1'b0};
							r_d.cnt     = r_q.cnt + 4'h1;
						end
					end
				end
				// sample the master's acknowledge
				D_ACKIN: begin
					if (scl_rise) begin
						r_d.ackin = r_q.sda_s[1];
					end else if (scl_fall) begin
						r_d.ist[`IRQ_EV_BIT] = 1'b1;
						if (r_q.ackin) begin
							r_d.st = D_IDLE;
						end else begin
							r_d.st      = D_TXWAIT;
							r_d.scl_low = 1'b1;
							r_d.clock_release_bit     = 1'b0;
						end
					end
				end
			endcase
		end
		if (!ce) begin
			r_d = r_q;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q       <= '0;
			r_q.st    <= D_IDLE;
			r_q.ret   <= D_IDLE;
			r_q.scl_s <= 3'h7;
			r_q.sda_s <= 3'h7;
			r_q.addr  <= `SSP_ADDR_RST;
			r_q.ist   <= `SSP_IRQ_RST;
			r_q.imask <= `SSP_IRQ_RST;
		end else begin
			r_q <= r_d;
		end
	end
endmodule : sync_serial_port_i2c_slave

// ===== i2c_bus_controller.sv
// controller end: two-wire master driven by apb commands
`timescale 1ns/1ns
`include "ssp_params.svh"
module i2c_bus_controller #(
	parameter int STEP_CYC = `SSP_HALF_BIT_CYC // cycles per bus step
) (
	input  wire logic          pclk,     // system clock
	input  wire logic          presetn,  // async reset, active low
	input  wire logic          ce,       // clock enable, freezes state when low
	input  wire logic          psel,     // apb select
	input  wire logic          penable,  // apb access phase
	input  wire logic          pwrite,   // apb direction
	input  wire ssp_pkg::addr_t paddr,   // apb byte address
	input  wire ssp_pkg::word_t pwdata,  // apb write data
	output ssp_pkg::word_t     prdata,   // apb read data
	output logic               pready,   // apb ready
	output logic               pslverr,  // apb error on unmapped address
	i2c_link_if.master         link      // two-wire pins
);
	import ssp_pkg::*;

	mst_regs_t r_q;
	mst_regs_t r_d;
	logic      is_byte;
	logic      is_start;
	logic      want_scl_low;
	logic      want_sda_low;
	logic      last;
	logic      step_end;
	logic      stalled;
	logic      acc;

	// per-step line levels of each command
	assign is_byte  = r_q.cmd[1];
	assign is_start = r_q.cmd == `MST_CMD_START;
	assign want_scl_low = is_byte ? (r_q.sub != 3'h2) :
		is_start ? (r_q.sub < 3'h2 || r_q.sub == 3'h4) : (r_q.sub < 3'h2);
	// outside the start and stop edges, data only moves in a step where the clock is already low
	assign want_sda_low = (r_q.sub == 3'h0) ? r_q.sda_low :
		is_byte ? ~r_q.tx[8] :
		is_start ? (r_q.sub >= 3'h3) : (r_q.sub != 3'h3);
	assign last = is_byte ? (r_q.sub == 3'h2 && r_q.bitn == 4'h8) :
		(r_q.sub == (is_start ? 3'h4 : 3'h3));
	assign step_end = r_q.tmr == 16'(STEP_CYC - 1);
	// a slave holding the clock low stretches the high step
	assign stalled  = ~want_scl_low & ~r_q.scl_s[1];
	assign acc      = psel & penable;

	assign pready  = acc;
	assign prdata  = r_q.rdata;
	assign pslverr = acc & r_q.err;
	assign link.mst_scl_o    = 1'b0;
	assign link.mst_sda_o    = 1'b0;
	assign link.mst_scl_oe_n = ~r_q.scl_low;
	assign link.mst_sda_oe_n = ~r_q.sda_low;

	// next state of the controller
	always_comb begin
		r_d = r_q;
		r_d.scl_s = {r_q.scl_s[1:0], link.scl};
		r_d.sda_s = {r_q.sda_s[1:0], link.sda};
		if (psel && !penable) begin
			r_d.err   = 1'b0;
			r_d.rdata = 32'h0000_0000;
			unique case (paddr)
				`MST_CMD_OFS:  ;
				`MST_STAT_OFS: r_d.rdata[15:0] = {r_q.rx[8:1], 6'h00, r_q.rx[0],
					r_q.st == M_RUN};
				default:       r_d.err = 1'b1;
			endcase
		end
		// a command written while busy is ignored
		if (acc && pwrite && paddr == `MST_CMD_OFS && r_q.st == M_IDLE) begin
			r_d.st   = M_RUN;
			r_d.cmd  = pwdata[9:8];
			r_d.sub  = 3'h0;
			r_d.bitn = 4'h0;
			r_d.tmr  = 16'h0000;
			// address byte carries the direction bit in its lsb
			r_d.tx   = (pwdata[9:8] == `MST_CMD_READ) ? {8'hFF, pwdata[10]} :
				{pwdata[7:0], 1'b1};
		end
		if (r_q.st == M_RUN) begin
			r_d.scl_low = want_scl_low;
			r_d.sda_low = want_sda_low;
			if (stalled) begin
				r_d.tmr = 16'h0000;
			end else if (!step_end) begin
				r_d.tmr = r_q.tmr + 16'h0001;
			end else begin
				r_d.tmr = 16'h0000;
				if (is_byte && r_q.sub == 3'h2) begin
					r_d.rx   = {r_q.rx[7:0], r_q.sda_s[1]};
					r_d.tx   = {r_q.tx[7:0], 1'b1};
					r_d.sub  = 3'h0;
					r_d.bitn = r_q.bitn + 4'h1;
				end else begin
					r_d.sub = r_q.sub + 3'h1;
				end
				// after a byte the clock is parked low, so the ninth fall
				// reaches the slave and it can stretch or raise its event
				if (last) begin
					r_d.st = M_IDLE;
					if (is_byte) begin
						r_d.scl_low = 1'b1;
					end
				end
			end
		end
		if (!ce) begin
			r_d = r_q;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q       <= '0;
			r_q.st    <= M_IDLE;
			r_q.scl_s <= 3'h7;
			r_q.sda_s <= 3'h7;
		end else begin
			r_q <= r_d;
		end
	end
endmodule : i2c_bus_controller

// ===== ssp_link_props.sv
// checker for the two-wire link between controller end and device end
`timescale 1ns/1ns
module ssp_link_props (
	input wire logic pclk,         // system clock
	input wire logic presetn,      // reset, active low
	input wire logic dev_scl_o,    // device clock level
	input wire logic dev_scl_oe_n, // device pulls clock, low active
	input wire logic dev_sda_o,    // device data level
	input wire logic dev_sda_oe_n, // device pulls data, low active
	input wire logic mst_scl_o,    // controller clock level
	input wire logic mst_scl_oe_n, // controller pulls clock, low active
	input wire logic mst_sda_o,    // controller data level
	input wire logic mst_sda_oe_n, // controller pulls data, low active
	input wire logic scl,          // resolved clock line
	input wire logic sda           // resolved data line
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// open-drain drive only
	AST_DEV_LOW: assert property (!dev_scl_o && !dev_sda_o)
		else $error("device drives a line high");
	AST_MST_LOW: assert property (!mst_scl_o && !mst_sda_o)
		else $error("controller drives a line high");
	AST_WIRED: assert property (scl == (dev_scl_oe_n && mst_scl_oe_n) && sda == (dev_sda_oe_n && mst_sda_oe_n))
		else $error("line level not wired-and");
	// device data moves only in the clock low phase
	AST_DEV_SDA_CHG: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
		else $error("device data changed with clock high");
	// stretching only grabs a clock already low
	AST_DEV_SCL_GRAB: assert property ($fell(dev_scl_oe_n) |-> !$past(scl))
		else $error("device pulled clock while high");
	AST_COND_BY_MST: assert property ($changed(sda) && scl && $past(scl) |-> !$changed(dev_sda_oe_n))
		else $error("device made a start or stop");
	AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*8])
		else $error("clock high phase too short");
	AST_STOP_FREE: assert property (scl && $past(scl) && $rose(sda) |=> (dev_sda_oe_n && dev_scl_oe_n) [*8])
		else $error("device holds a line after stop");
	// main scenarios
	COV_START: cover property (scl && $past(scl) && $fell(sda));
	COV_STOP: cover property (scl && $past(scl) && $rose(sda));
	COV_STRETCH: cover property ($fell(dev_scl_oe_n));
	COV_ACK: cover property ($fell(dev_sda_oe_n));
endmodule : ssp_link_props

// ===== sync_serial_port_i2c_slave_test.sv
// self-checking bench: controller end talks to device end over the link
`timescale 1ns/1ns
`include "ssp_params.svh"
module sync_serial_port_i2c_slave_test;
	import ssp_pkg::*;
	typedef struct {string n; logic [34:0] m; logic [34:0] e;} note_t;
	localparam logic [34:0] SCLB = 35'h400000000;
	localparam logic [34:0] ERRB = 35'h200000000;
	localparam logic [34:0] IRQB = 35'h100000000;
	logic        pclk;
	logic        presetn;
	logic        psel [2];
	logic        penable [2];
	logic        pwrite [2];
	logic        pready [2];
	logic        pslverr [2];
	logic        irq;
	addr_t       paddr [2];
	word_t       pwdata [2];
	word_t       prdata [2];
	word_t       v;
	int          fails;
	int          compares;
	int          cyc;
	note_t       notes [$];
	note_t       x;
	logic [34:0] o;
	logic [7:0]  r;
	logic [7:0]  t;
	i2c_link_if link ();
	sync_serial_port_i2c_slave sync_serial_port_i2c_slave_i (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel[0]), .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]),
		.pwdata(pwdata[0]), .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]),
		.irq(irq), .link(link.device));
	i2c_bus_controller #(.STEP_CYC(20)) i2c_bus_controller_i (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel[1]), .penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]),
		.pwdata(pwdata[1]), .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]),
		.link(link.master));
	ssp_link_props ssp_link_props_i (.pclk(pclk), .presetn(presetn),
		.dev_scl_o(link.dev_scl_o), .dev_scl_oe_n(link.dev_scl_oe_n),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe_n(link.dev_sda_oe_n),
		.mst_scl_o(link.mst_scl_o), .mst_scl_oe_n(link.mst_scl_oe_n),
		.mst_sda_o(link.mst_sda_o), .mst_sda_oe_n(link.mst_sda_oe_n),
		.scl(link.scl), .sda(link.sda));
	// clock
	always #5 pclk = ~pclk;
	// verdict and end of run
	task automatic wrap_up;
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// one apb transfer; reads leave a note for the monitor
	task automatic apb(input int p, input bit w, input addr_t a, input word_t d,
		input string n = "", input logic [34:0] m = '0, input logic [34:0] e = '0);
		@(posedge pclk);
		psel[p] <= 1'b1;
		penable[p] <= 1'b0;
		pwrite[p] <= w;
		paddr[p] <= a;
		pwdata[p] <= d;
		if (!w) notes.push_back('{n, m, e});
		@(posedge pclk);
		penable[p] <= 1'b1;
		do @(posedge pclk); while (pready[p] !== 1'b1);
		v = prdata[p];
		psel[p] <= 1'b0;
		penable[p] <= 1'b0;
	endtask : apb
	task automatic wr(input int p, input addr_t a, input word_t d);
		apb(p, 1'b1, a, d);
	endtask : wr
	task automatic chk(input int p, input addr_t a, input string n, input logic [34:0] m,
		input logic [34:0] e);
		apb(p, 1'b0, a, 32'h0, n, m, e);
	endtask : chk
	// controller command, then poll until idle
	task automatic cmd(input logic [1:0] c, input logic [7:0] b = 8'h0, input bit k = 1'b0);
		wr(1, `MST_CMD_OFS, {21'h0, k, c, b});
		do apb(1, 1'b0, `MST_STAT_OFS, 32'h0); while (v[0] !== 1'b0);
	endtask : cmd
	// monitor: compare each finished read with its note
	always @(posedge pclk) begin
		for (int p = 0; p < 2; p++) begin
			if (psel[p] && penable[p] && pready[p] && !pwrite[p]) begin
				x = notes.pop_front();
				o = {link.scl, pslverr[p], irq, prdata[p]} & x.m;
				if (x.m != '0) compares++;
				if (x.m != '0 && o !== x.e) begin
					fails++;
					$display("[FAIL] %s expected %h seen %h", x.n, x.e, o);
				end
			end
		end
	end
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		fails = 0;
		compares = 0;
		cyc = 0;
		for (int p = 0; p < 2; p++) begin
			psel[p] = 1'b0;
			penable[p] = 1'b0;
			pwrite[p] = 1'b0;
			paddr[p] = 8'h00;
			pwdata[p] = 32'h0;
		end
		void'($urandom(32'h693C));
		r = 8'($urandom);
		t = 8'($urandom);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unmapped place, sample phase field
		chk(0, `SSP_ADDR_OFS, "addr", 35'hFF, 35'h0);
		chk(0, `SSP_CTRL_OFS, "ctrl", IRQB | 35'h7, 35'h0);
		chk(0, `SSP_STAT_OFS, "status", 35'hFF, 35'h0);
		chk(0, 8'h98, "unmapped", ERRB | 35'hFFFFFFFF, ERRB);
		wr(0, `SSP_STAT_OFS, 32'h80);
		chk(0, `SSP_STAT_OFS, "sample phase", 35'h80, 35'h80);
		wr(0, `SSP_ADDR_OFS, 32'hA0);
		wr(0, `SSP_CTRL_OFS, 32'h1);
		wr(0, `SSP_IMASK_OFS, 32'h7);
		// write transfer, then overflow
		cmd(`MST_CMD_START);
		chk(0, `SSP_STAT_OFS, "start seen", 35'h18, 35'h8);
		cmd(`MST_CMD_WRITE, 8'hA0);
		chk(1, `MST_STAT_OFS, "addr ack", 35'h2, 35'h0);
		chk(0, `SSP_ISTAT_OFS, "addr event", IRQB | 35'h7, IRQB | 35'h1);
		chk(0, `SSP_STAT_OFS, "addr status", 35'h25, 35'h1);
		chk(0, `SSP_DATA_OFS, "addr byte", 35'hFF, 35'hA0);
		wr(0, `SSP_ISTAT_OFS, 32'h1);
		cmd(`MST_CMD_WRITE, r);
		chk(1, `MST_STAT_OFS, "data ack", 35'h2, 35'h0);
		chk(0, `SSP_STAT_OFS, "data status", 35'h21, 35'h21);
		cmd(`MST_CMD_WRITE, ~r);
		chk(1, `MST_STAT_OFS, "overflow nak", 35'h2, 35'h2);
		wr(0, `SSP_ISTAT_OFS, 32'h1);
		chk(0, `SSP_ISTAT_OFS, "overflow kept", IRQB | 35'h3, IRQB | 35'h2);
		chk(0, `SSP_DATA_OFS, "first byte", 35'hFF, {27'h0, r});
		wr(0, `SSP_IMASK_OFS, 32'h0);
		chk(0, `SSP_ISTAT_OFS, "masked", IRQB, 35'h0);
		wr(0, `SSP_IMASK_OFS, 32'h7);
		cmd(`MST_CMD_STOP);
		chk(0, `SSP_STAT_OFS, "stop seen", 35'h1C, 35'h10);
		wr(0, `SSP_ISTAT_OFS, 32'h7);
		// foreign address gets no answer
		cmd(`MST_CMD_START);
		cmd(`MST_CMD_WRITE, 8'hB2);
		chk(1, `MST_STAT_OFS, "foreign nak", 35'h2, 35'h2);
		chk(0, `SSP_ISTAT_OFS, "foreign quiet", IRQB | 35'h7, 35'h0);
		cmd(`MST_CMD_STOP);
		// read transfer with stretching
		cmd(`MST_CMD_START);
		cmd(`MST_CMD_WRITE, 8'hA1);
		chk(0, `SSP_STAT_OFS, "read dir", SCLB | 35'h4, 35'h4);
		wr(0, `SSP_DATA_OFS, {24'h0, t});
		cmd(`MST_CMD_READ);
		chk(1, `MST_STAT_OFS, "first sent", 35'hFF00, {19'h0, t, 8'h0});
		wr(0, `SSP_DATA_OFS, {24'h0, ~t});
		cmd(`MST_CMD_READ, 8'h0, 1'b1);
		chk(1, `MST_STAT_OFS, "last sent", 35'hFF00, {19'h0, ~t, 8'h0});
		cmd(`MST_CMD_STOP);
		chk(0, `SSP_STAT_OFS, "bus free", SCLB | 35'h4, SCLB);
		// ten-bit addressing
		wr(0, `SSP_CTRL_OFS, 32'h5);
		wr(0, `SSP_ADDR_OFS, 32'hF6);
		wr(0, `SSP_ISTAT_OFS, 32'h7);
		cmd(`MST_CMD_START);
		cmd(`MST_CMD_WRITE, 8'hF6);
		chk(0, `SSP_STAT_OFS, "high match", SCLB | 35'h2, 35'h2);
		chk(0, `SSP_DATA_OFS, "high byte", 35'h0, 35'h0);
		wr(0, `SSP_ADDR_OFS, 32'h5A);
		chk(0, `SSP_STAT_OFS, "update cleared", 35'h2, 35'h0);
		cmd(`MST_CMD_WRITE, 8'h5A);
		chk(1, `MST_STAT_OFS, "low ack", 35'h2, 35'h0);
		chk(0, `SSP_STAT_OFS, "low match", SCLB | 35'h2, 35'h2);
		chk(0, `SSP_DATA_OFS, "low byte", 35'h0, 35'h0);
		wr(0, `SSP_ADDR_OFS, 32'hF6);
		cmd(`MST_CMD_WRITE, r);
		chk(0, `SSP_DATA_OFS, "ten-bit data", 35'hFF, {27'h0, r});
		cmd(`MST_CMD_START);
		cmd(`MST_CMD_WRITE, 8'hF7);
		chk(1, `MST_STAT_OFS, "read high ack", 35'h2, 35'h0);
		wr(0, `SSP_DATA_OFS, {24'h0, t});
		cmd(`MST_CMD_READ, 8'h0, 1'b1);
		chk(1, `MST_STAT_OFS, "ten-bit sent", 35'hFF00, {19'h0, t, 8'h0});
		cmd(`MST_CMD_STOP);
		wrap_up();
	end
endmodule : sync_serial_port_i2c_slave_test
